// ---- common/seq_pkg.sv ----
// constants, types and register map of the program sequencer
// assumes one instruction-cycle clock shared with the core
package seq_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int ADDR_W = 11;
   localparam int WORD_W = 14;
   localparam int ROM_DEPTH = 2048;
   localparam int STACK_DEPTH = 4;
   localparam int BUS_AW = 8;

   // ------------------------------------------------------------
   // vectors and fixed page
   // ------------------------------------------------------------
   localparam logic [10:0] RESET_VEC = 11'h000;
   localparam logic [10:0] USB_VEC = 11'h004;
   localparam logic [10:0] TIMER_VEC = 11'h00c;
   localparam logic [2:0] LAST_PAGE = 3'h7;

   // ------------------------------------------------------------
   // register indexes (byte address is index times four)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_COUNTER_LOW = 6'h06;
   localparam logic [5:0] IDX_TABLE_PTR_LOW = 6'h07;
   localparam logic [5:0] IDX_TABLE_UPPER = 6'h08;
   localparam logic [5:0] IDX_TABLE_PTR_HIGH = 6'h1f;
   localparam logic [5:0] IDX_OPTION = 6'h20;

   localparam logic [7:0] PTR_LOW_RST = 8'h00;
   localparam logic [7:0] PTR_HIGH_RST = 8'h00;
   localparam logic [5:0] UPPER_RST = 6'h00;
   localparam logic OPTION_RST = 1'b0;
   localparam int OPT_HIGH_PTR_BIT = 0;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NEXT, OP_SKIP, OP_JUMP, OP_CALL,
      OP_RET, OP_RETI, OP_TAB_CUR, OP_TAB_LAST
   } op_t;

   typedef struct packed {
      op_t op;
      logic [10:0] target;
   } cmd_t;

   typedef struct packed {
      logic valid;
      logic [10:0] addr;
      logic [13:0] word;
   } fetch_t;

   typedef struct packed {
      logic valid;
      logic [7:0] low_byte;
   } table_t;

   typedef enum logic {ST_RUN, ST_TABLE} seq_state_t;

endpackage

// ---- src/program_sequencer_table_read.sv ----
// instruction address counter, program store, return stack and
// table read unit, with its registers on a classic wishbone slave
// assumes the core gives one command per instruction cycle and
// has already gated interrupt requests with their enables
//
// Behaviour
// - counter advances by one after each fetch
// - program store is 2048 words of 14 bits
// - reset clears counter to address zero
// - usb interrupt loads vector 004h
// - timer overflow interrupt loads vector 00ch
// - taken skip drops prefetch, continues at plus two
// - low-byte write jumps within current page, but is dropped in a table read's second cycle
// - every control transfer costs one dummy cycle
// - jump/call from code, return from stack
// - option off: table page from counter
// - option on: table page from high pointer
// - last-page table read forces page seven
// - table upper bits to upper register, rest zero
// - upper register read-only, changed by table reads
// - both table pointers readable and writable
// - each table read takes two cycles
// - only high pointer bits 2..0 are used
// - call and interrupt push, returns pop
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module program_sequencer_table_read (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire seq_pkg::cmd_t cmd_in,
   input wire logic usb_irq_in,
   input wire logic timer_irq_in,
   input wire logic rom_we_in,
   input wire logic [10:0] rom_addr_in,
   input wire logic [13:0] rom_data_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output seq_pkg::fetch_t fetch_out,
   output seq_pkg::table_t table_out,
   output logic usb_ack_out,
   output logic timer_ack_out,
   output logic stack_full_out
);
   import seq_pkg::*;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [13:0] rom_mem [ROM_DEPTH];
   logic [10:0] stack_mem [STACK_DEPTH];
   logic [10:0] pc_q, pc_d;
   logic [1:0] sp_q, sp_d;
   logic [2:0] depth_q, depth_d;
   seq_state_t state_q, state_d;
   fetch_t fetch_q;
   table_t table_q;
   logic [10:0] tbl_addr_q;
   logic [7:0] ptr_low_q, ptr_high_q;
   logic [5:0] upper_q;
   logic option_q;
   logic ack_q;
   logic [31:0] dat_q;

   // ------------------------------------------------------------
   // wishbone decode
   // ------------------------------------------------------------
   wire bus_req = wb_cyc_in & wb_stb_in;
   wire [5:0] bus_idx = wb_adr_in[7:2];
   wire bus_wr = bus_req & wb_we_in & ack_q & wb_sel_in[0];
   wire hit_pcl = bus_idx == IDX_COUNTER_LOW;
   wire hit_plow = bus_idx == IDX_TABLE_PTR_LOW;
   wire hit_upper = bus_idx == IDX_TABLE_UPPER;
   wire hit_phigh = bus_idx == IDX_TABLE_PTR_HIGH;
   wire hit_opt = bus_idx == IDX_OPTION;
   wire pcl_wr = bus_wr & hit_pcl;
   wire [7:0] rd_byte = hit_pcl ? pc_q[7:0] :
                        hit_plow ? ptr_low_q :
                        hit_upper ? {2'b00, upper_q} :
                        hit_phigh ? ptr_high_q :
                        hit_opt ? {7'h00, option_q} : 8'h00;

   // ------------------------------------------------------------
   // sequencing decisions
   // ------------------------------------------------------------
   wire running = state_q == ST_RUN;
   wire stack_full = depth_q == 3'(STACK_DEPTH);
   wire idle_slot = running & ~pcl_wr & (cmd_in.op == OP_NEXT);
   // usb outranks timer; a full stack holds both off
   wire usb_take = idle_slot & ~stack_full & usb_irq_in;
   wire timer_take = idle_slot & ~stack_full & ~usb_irq_in
                     & timer_irq_in;
   wire skip_take = running & ~pcl_wr & (cmd_in.op == OP_SKIP);
   wire tab_cur = running & ~pcl_wr & (cmd_in.op == OP_TAB_CUR);
   wire tab_last = running & ~pcl_wr & (cmd_in.op == OP_TAB_LAST);
   wire [2:0] cur_page = option_q ? ptr_high_q[2:0] : pc_q[10:8];
   wire [10:0] tbl_addr_d = tab_last ? {LAST_PAGE, ptr_low_q}
                                     : {cur_page, ptr_low_q};
   // table cycle borrows the single read port
   wire [10:0] rom_addr = running ? pc_q : tbl_addr_q;
   wire [13:0] rd_word = rom_mem[rom_addr];

   logic push, pop, fetch_ok;
   always_comb begin
      pc_d = pc_q + 11'h001;
      state_d = state_q;
      push = 1'b0;
      pop = 1'b0;
      fetch_ok = 1'b1;
      if (!running) begin
         // second cycle of a table read
         pc_d = pc_q;
         fetch_ok = 1'b0;
         state_d = ST_RUN;
      end else if (pcl_wr) begin
         pc_d = {pc_q[10:8], wb_dat_in[7:0]};
         fetch_ok = 1'b0;
      end else if (usb_take) begin
         pc_d = USB_VEC;
         push = 1'b1;
         fetch_ok = 1'b0;
      end else if (timer_take) begin
         pc_d = TIMER_VEC;
         push = 1'b1;
         fetch_ok = 1'b0;
      end else begin
         case (cmd_in.op)
            OP_SKIP: begin
               fetch_ok = 1'b0;
            end
            OP_JUMP: begin
               pc_d = cmd_in.target;
               fetch_ok = 1'b0;
            end
            OP_CALL: begin
               pc_d = cmd_in.target;
               push = 1'b1;
               fetch_ok = 1'b0;
            end
            OP_RET, OP_RETI: begin
               pc_d = stack_mem[sp_q];
               pop = 1'b1;
               fetch_ok = 1'b0;
            end
            OP_TAB_CUR, OP_TAB_LAST: begin
               state_d = ST_TABLE;
            end
            default: pc_d = pc_q + 11'h001;
         endcase
      end
   end

   // circular stack: an overflowing push loses the oldest entry
   always_comb begin
      sp_d = sp_q;
      depth_d = depth_q;
      if (push) begin
         sp_d = sp_q + 2'h1;
         depth_d = stack_full ? depth_q : depth_q + 3'h1;
      end else if (pop) begin
         sp_d = sp_q - 2'h1;
         depth_d = (depth_q == 3'h0) ? depth_q : depth_q - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // counter, stack and fetch registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pc_q <= RESET_VEC;
         sp_q <= 2'h0;
         depth_q <= 3'h0;
         state_q <= ST_RUN;
         fetch_q <= '0;
      end else begin
         pc_q <= pc_d;
         sp_q <= sp_d;
         depth_q <= depth_d;
         state_q <= state_d;
         fetch_q.addr <= pc_q;
         fetch_q.word <= rd_word;
         fetch_q.valid <= fetch_ok;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         stack_mem[sp_d] <= pc_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rom_we_in) begin
         rom_mem[rom_addr_in] <= rom_data_in;
      end
   end

   // ------------------------------------------------------------
   // table read unit
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tbl_addr_q <= RESET_VEC;
         table_q <= '0;
         upper_q <= UPPER_RST;
      end else begin
         if (tab_cur | tab_last) begin
            tbl_addr_q <= tbl_addr_d;
         end
         table_q.valid <= ~running;
         if (!running) begin
            table_q.low_byte <= rd_word[7:0];
            upper_q <= rd_word[13:8];
         end
      end
   end

   // ------------------------------------------------------------
   // software registers and bus answer
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ptr_low_q <= PTR_LOW_RST;
         ptr_high_q <= PTR_HIGH_RST;
         option_q <= OPTION_RST;
      end else if (bus_wr) begin
         if (hit_plow) begin
            ptr_low_q <= wb_dat_in[7:0];
         end
         if (hit_phigh) begin
            ptr_high_q <= wb_dat_in[7:0];
         end
         if (hit_opt) begin
            option_q <= wb_dat_in[OPT_HIGH_PTR_BIT];
         end
      end
   end

   // one wait state; unmapped reads answer zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q) begin
            dat_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = dat_q;
   assign fetch_out = fetch_q;
   assign table_out = table_q;
   assign usb_ack_out = usb_take;
   assign timer_ack_out = timer_take;
   assign stack_full_out = stack_full;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // the last reset edge must not start a step check
   wire plain_step = ~rst_in & idle_slot & ~usb_take & ~timer_take;
   sequence s_dummy;
      !fetch_q.valid;
   endsequence
   sequence s_table_done;
      state_q == ST_TABLE ##1 table_q.valid && state_q == ST_RUN;
   endsequence
   property p_reset_zero;
      @(posedge clk_in) rst_in |=> pc_q == 11'h000;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("counter not zero after reset");

   property p_step;
      @(posedge clk_in) disable iff (rst_in)
      plain_step |=> pc_q == $past(pc_q) + 11'h001 && fetch_q.valid;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not advance by one");

   property p_usb_vec;
      @(posedge clk_in) disable iff (rst_in)
      usb_take |=> pc_q == 11'h004 and s_dummy;
   endproperty
   a_usb_vec: assert property (p_usb_vec)
      else $error("usb vector not loaded");

   property p_timer_vec;
      @(posedge clk_in) disable iff (rst_in)
      timer_take |=> pc_q == 11'h00c and s_dummy;
   endproperty
   a_timer_vec: assert property (p_timer_vec)
      else $error("timer vector not loaded");

   property p_skip;
      @(posedge clk_in) disable iff (rst_in)
      skip_take |=> s_dummy ##0 pc_q == $past(pc_q) + 11'h001;
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip did not reach plus two");

   property p_pcl;
      @(posedge clk_in) disable iff (rst_in)
      pcl_wr |=> pc_q == {$past(pc_q[10:8]), $past(wb_dat_in[7:0])}
                 ##0 !fetch_q.valid;
   endproperty
   a_pcl: assert property (p_pcl)
      else $error("low byte jump wrong");

   property p_jump;
      @(posedge clk_in) disable iff (rst_in)
      running && !pcl_wr && cmd_in.op == OP_JUMP
      |=> pc_q == $past(cmd_in.target) and s_dummy;
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump target not loaded");

   property p_call_ret;
      @(posedge clk_in) disable iff (rst_in)
      running && !pcl_wr && !stack_full && cmd_in.op == OP_CALL
      ##1 running && cmd_in.op == OP_RET
      |=> pc_q == $past(pc_q, 2);
   endproperty
   a_call_ret: assert property (p_call_ret)
      else $error("return address not restored");

   property p_table_two;
      @(posedge clk_in) disable iff (rst_in)
      (tab_cur || tab_last) |=> s_table_done;
   endproperty
   a_table_two: assert property (p_table_two)
      else $error("table read not two cycles");

   property p_last_page;
      @(posedge clk_in) disable iff (rst_in)
      tab_last |=> tbl_addr_q == {3'h7, $past(ptr_low_q)};
   endproperty
   a_last_page: assert property (p_last_page)
      else $error("last page address wrong");

   property p_upper_ro;
      @(posedge clk_in) disable iff (rst_in)
      running |=> $stable(upper_q);
   endproperty
   a_upper_ro: assert property (p_upper_ro)
      else $error("upper register changed outside table read");
endmodule

// ---- tb/program_sequencer_table_read_tb.sv ----
// self-checking bench for the program sequencer and table read unit
// assumes the sequencer's own assertions sit inside the design file
`timescale 1ns/1ps
module program_sequencer_table_read_tb;
   import seq_pkg::*;

   // ------------------------------------------------------------
   // stimulus and observation
   // ------------------------------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   cmd_t cmd_in = '{op: OP_NEXT, target: 11'h000};
   logic usb_irq_in = 1'b0;
   logic timer_irq_in = 1'b0;
   logic rom_we_in = 1'b0;
   logic [10:0] rom_addr_in = 11'h000;
   logic [13:0] rom_data_in = 14'h0000;
   logic wb_cyc_in = 1'b0;
   logic wb_stb_in = 1'b0;
   logic wb_we_in = 1'b0;
   logic [7:0] wb_adr_in = 8'h00;
   logic [3:0] wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [31:0] wb_dat_out;
   logic wb_ack_out;
   fetch_t fetch_out;
   table_t table_out;
   logic usb_ack_out;
   logic timer_ack_out;
   logic stack_full_out;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [10:0] exec_addr;
   logic [10:0] ret_q [4];
   logic [10:0] loads [5] = '{11'h123, 11'h35a, 11'h55a, 11'h75a,
      11'h000};

   always #50 clk_in = ~clk_in;

   program_sequencer_table_read dut (
      .clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
      .usb_irq_in(usb_irq_in), .timer_irq_in(timer_irq_in),
      .rom_we_in(rom_we_in), .rom_addr_in(rom_addr_in),
      .rom_data_in(rom_data_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
      .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
      .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .fetch_out(fetch_out),
      .table_out(table_out), .usb_ack_out(usb_ack_out),
      .timer_ack_out(timer_ack_out), .stack_full_out(stack_full_out));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // page number repeated above the address keeps every page distinct
   function automatic logic [13:0] rom_word(input logic [10:0] a);
      return {a[10:8], a};
   endfunction

   task automatic complete_run();
      if (n_fail == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h want %h", $time, what,
            got, exp);
      end
   endtask

   // classic single cycle; release only at the edge that saw ack
   task automatic wb_cycle(input logic we, input logic [7:0] adr,
      input logic [7:0] wdat, output logic [31:0] rdat);
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_sel_in <= 4'hf;
      wb_dat_in <= {24'h0, wdat};
      // ends when ack is seen; only the bench timeout ends a wait for a missing ack
      do begin
         @(posedge clk_in);
      end while (wb_ack_out !== 1'b1);
      rdat = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [31:0] r;
      wb_cycle(1'b1, adr, d, r);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      wb_cycle(1'b0, adr, 8'h00, r);
      check(r, exp, "register read");
   endtask

   // returns at the edge that takes the command
   task automatic issue(input op_t op, input logic [10:0] tgt);
      @(posedge clk_in);
      cmd_in <= '{op: op, target: tgt};
      #1 exec_addr = fetch_out.addr;
      @(posedge clk_in);
      cmd_in <= '{op: OP_NEXT, target: 11'h000};
   endtask

   task automatic xfer(input op_t op, input logic [10:0] tgt, exp,
      input logic rel);
      issue(op, tgt);
      #1 check(fetch_out.valid, 1'b0, "dummy cycle");
      @(posedge clk_in);
      #1 check(fetch_out.addr, rel ? exec_addr + exp : exp, "landing");
      check(fetch_out.valid, 1'b1, "landing valid");
   endtask

   task automatic table_read(input op_t op, input logic [10:0] a);
      issue(op, 11'h000);
      @(posedge clk_in);
      #1 check(table_out, {1'b1, a[7:0]}, "table low byte");
      check(fetch_out.valid, 1'b0, "table second cycle");
      @(posedge clk_in);
      #1 check(table_out.valid, 1'b0, "table pulse");
      rd(8'h20, 32'(rom_word(a) >> 8));
   endtask

   task automatic irq(input logic u, t, input logic [10:0] vec);
      @(posedge clk_in);
      usb_irq_in <= u;
      timer_irq_in <= t;
      #1 exec_addr = fetch_out.addr;
      check({usb_ack_out, timer_ack_out}, {u, t & ~u}, "irq taken");
      @(posedge clk_in);
      usb_irq_in <= 1'b0;
      timer_irq_in <= 1'b0;
      #1 check(fetch_out.valid, 1'b0, "irq dummy");
      @(posedge clk_in);
      #1 check(fetch_out.addr, vec, "irq vector");
   endtask

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [10:0] ra;
      foreach (loads[i]) begin
         @(posedge clk_in);
         rom_we_in <= 1'b1;
         rom_addr_in <= loads[i];
         rom_data_in <= rom_word(loads[i]);
      end
      @(posedge clk_in);
      rom_we_in <= 1'b0;
      repeat (14) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1 check(fetch_out, {1'b1, 11'h000, rom_word(11'h000)}, "start");
      @(posedge clk_in);
      #1 check(fetch_out.addr, 11'h001, "increment");
      rd(8'h1c, 32'h0);
      rd(8'h7c, 32'h0);
      rd(8'h20, 32'h0);
      wr(8'h1c, 8'h5a);
      wr(8'h7c, 8'hfd);
      wr(8'h20, 8'hff);
      wr(8'h40, 8'hff);
      rd(8'h1c, 32'h5a);
      rd(8'h7c, 32'hfd);
      rd(8'h20, 32'h0);
      rd(8'h40, 32'h0);
      xfer(OP_JUMP, 11'h123, 11'h123, 1'b0);
      check(fetch_out.word, rom_word(11'h123), "fetched word");
      xfer(OP_SKIP, 11'h000, 11'h002, 1'b1);
      xfer(OP_JUMP, 11'h300, 11'h300, 1'b0);
      table_read(OP_TAB_CUR, 11'h35a);
      table_read(OP_TAB_LAST, 11'h75a);
      wr(8'h80, 8'h01);
      table_read(OP_TAB_CUR, 11'h55a);
      wr(8'h18, 8'h80);
      #1 check(fetch_out.valid, 1'b0, "short jump dummy");
      @(posedge clk_in);
      #1 check(fetch_out.addr, 11'h380, "short jump");
      xfer(OP_CALL, 11'h200, 11'h200, 1'b0);
      ra = exec_addr + 11'h001;
      xfer(OP_RET, 11'h000, ra, 1'b0);
      @(posedge clk_in);
      cmd_in <= '{op: OP_CALL, target: 11'h600};
      #1 ra = fetch_out.addr + 11'h001;
      @(posedge clk_in);
      cmd_in <= '{op: OP_RET, target: 11'h000};
      @(posedge clk_in);
      cmd_in <= '{op: OP_NEXT, target: 11'h000};
      @(posedge clk_in);
      #1 check(fetch_out.addr, ra, "immediate return");
      for (int k = 0; k < 3; k++) begin
         irq(k != 1, k != 0, k == 1 ? TIMER_VEC : USB_VEC);
         ra = exec_addr + 11'h001;
         xfer(OP_RETI, 11'h000, ra, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         xfer(OP_CALL, 11'h400 + 11'(k), 11'h400 + 11'(k), 1'b0);
         ret_q[k] = exec_addr + 11'h001;
      end
      check(stack_full_out, 1'b1, "stack full");
      @(posedge clk_in);
      timer_irq_in <= 1'b1;
      #1 check(timer_ack_out, 1'b0, "irq held off");
      @(posedge clk_in);
      timer_irq_in <= 1'b0;
      #1 check(fetch_out.valid, 1'b1, "no vector taken");
      for (int k = 3; k >= 0; k--)
         xfer(OP_RET, 11'h000, ret_q[k], 1'b0);
      check(stack_full_out, 1'b0, "stack drained");
      complete_run();
   end
endmodule
